// ---- rtl/tw_pkg.sv ----
// Shared constants and types for the 16-bit timer waveform control block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses; each register
// takes one word at four times its index.
package tw_pkg;

	// Register indices (byte address is index * 4)
	localparam logic [5:0] TW_IDX_CTRL_A      = 6'h00;
	localparam logic [5:0] TW_IDX_CTRL_B      = 6'h01;
	localparam logic [5:0] TW_IDX_OUT_VALUE   = 6'h02;
	localparam logic [5:0] TW_IDX_SPLIT       = 6'h03;
	localparam logic [5:0] TW_IDX_CMD_DIR_CLR = 6'h04;
	localparam logic [5:0] TW_IDX_CMD_DIR_SET = 6'h05;
	localparam logic [5:0] TW_IDX_BV_CLR      = 6'h06;
	localparam logic [5:0] TW_IDX_BV_SET      = 6'h07;
	localparam logic [5:0] TW_IDX_COUNT       = 6'h20;
	localparam logic [5:0] TW_IDX_PERIOD      = 6'h26;
	localparam logic [5:0] TW_IDX_COMPARE_REGISTER_0        = 6'h28;
	localparam logic [5:0] TW_IDX_PERIOD_BUF  = 6'h36;
	localparam logic [5:0] TW_IDX_COMPARE_REGISTER_0_BUF    = 6'h38;
	localparam logic [5:0] TW_IDX_STRIDE      = 6'h02;

	// Field positions
	localparam int TW_POS_ENABLE    = 0;
	localparam int TW_POS_AUTO_LOCK = 3;
	localparam int TW_POS_CMP_EN    = 4;
	localparam int TW_POS_SPLIT     = 0;
	localparam int TW_POS_DIR       = 0;
	localparam int TW_POS_LOCK      = 1;
	localparam int TW_POS_CMD       = 2;
	localparam int TW_POS_PERIOD_BV = 0;
	localparam int TW_POS_CMP_BV    = 1;

	// Reset values
	localparam logic [7:0]  TW_RST_REG8  = 8'h00;
	localparam logic [15:0] TW_RST_TIMER = 16'h0000;

	typedef enum logic [2:0] {
		TW_WG_NORMAL    = 3'h0,
		TW_WG_FREQUENCY = 3'h1,
		TW_WG_SINGLE    = 3'h3,
		TW_WG_DUAL_HIGH = 3'h5,
		TW_WG_DUAL_BOTH = 3'h6,
		TW_WG_DUAL_LOW  = 3'h7
	} tw_waveform_mode_t;

	typedef enum logic [1:0] {
		TW_CMD_NONE    = 2'h0,
		TW_CMD_UPDATE  = 2'h1,
		TW_CMD_RESTART = 2'h2,
		TW_CMD_RESET   = 2'h3
	} tw_cmd_t;

	typedef enum logic [1:0] {
		TW_BUS_IDLE = 2'b01,
		TW_BUS_ACK  = 2'b10
	} tw_bus_t;

	typedef struct packed {
		tw_bus_t          bus;
		logic             wait_rq;
		logic [31:0]      rdata;
		logic             enable;
		logic [2:0]       cmp_en;
		logic             auto_lock;
		logic [2:0]       mode;
		logic [2:0]       out_value;
		logic             split;
		logic             lock;
		logic             dir;
		logic [3:0]       bv;
		logic [15:0]      cnt;
		logic [15:0]      period;
		logic [15:0]      period_buf;
		logic [2:0][15:0] cmp;
		logic [2:0][15:0] cmp_buf;
		logic [2:0]       wave;
		logic [2:0]       pin_out;
		logic [2:0]       pin_oe;
		logic [2:0]       logic_out;
		logic             update_p;
		logic             ovf_p;
	} tw_state_t;

endpackage : tw_pkg

// ---- rtl/tw_timer_ctrl.sv ----
// 16-bit timer waveform control: modes, buffers, set/clear pairs, outputs.
// Assumes an Avalon-MM master on clk and a port output value from the same
// clock domain; pads and configurable logic take the waveform outputs.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
module tw_timer_ctrl
	import tw_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [2:0]  port_value,
	output logic [2:0]       waveform_output,
	output logic [2:0]       waveform_output_oe,
	output logic [2:0]       logic_waveform,
	output logic             update_pulse,
	output logic             overflow_pulse,
	output logic             split_select
);

	function automatic logic [3:0] apply_sc(input logic [3:0] cur,
		input logic [3:0] set, input logic [3:0] clr);
		apply_sc = (cur & ~clr) | set;
	endfunction : apply_sc

	function automatic logic [15:0] merge16(input logic [15:0] cur,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
	endfunction : merge16

	tw_state_t   st_q;
	tw_state_t   st_d;
	logic        wr_acc;
	logic        we8;
	logic [5:0]  idx;
	logic [7:0]  wd8;
	logic [1:0]  cmd;
	logic [15:0] top;
	logic        at_top;
	logic        at_bot;
	logic        hw_upd;
	logic        force_upd;
	logic        cmd_rst_req;
	logic        hard_rst;
	logic        xfer;
	logic        any_buf_wr;
	logic        all_valid;

	always_comb begin
		st_d = st_q;
		st_d.update_p = 1'b0;
		st_d.ovf_p = 1'b0;
		hw_upd = 1'b0;
		force_upd = 1'b0;
		cmd_rst_req = 1'b0;
		hard_rst = 1'b0;
		any_buf_wr = 1'b0;
		idx = avs_address[7:2];
		wd8 = avs_writedata[7:0];
		wr_acc = (st_q.bus == TW_BUS_ACK) && avs_write;
		we8 = wr_acc && avs_byteenable[0];
		cmd = (we8 && idx == TW_IDX_CMD_DIR_SET) ? wd8[3:2] : TW_CMD_NONE;
		top = (st_q.mode == TW_WG_FREQUENCY) ? st_q.cmp[0]
			: st_q.period;
		at_top = (st_q.cnt == top);
		at_bot = (st_q.cnt == TW_RST_TIMER);

		// Bus: one wait cycle, then the answer stands for one cycle
		case (st_q.bus)
			TW_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					st_d.bus = TW_BUS_ACK;
					st_d.wait_rq = 1'b0;
					st_d.rdata = '0;
					case (idx)
						TW_IDX_CTRL_A: st_d.rdata[0] = st_q.enable;
						TW_IDX_CTRL_B: st_d.rdata[6:0] = {st_q.cmp_en, st_q.auto_lock,
							st_q.mode};
						TW_IDX_OUT_VALUE: st_d.rdata[2:0] = st_q.out_value;
						TW_IDX_SPLIT: st_d.rdata[0] = st_q.split;
						TW_IDX_CMD_DIR_CLR, TW_IDX_CMD_DIR_SET: begin
							st_d.rdata[1:0] = {st_q.lock, st_q.dir};
						end
						TW_IDX_BV_CLR, TW_IDX_BV_SET: st_d.rdata[3:0] = st_q.bv;
						TW_IDX_COUNT: st_d.rdata[15:0] = st_q.cnt;
						TW_IDX_PERIOD: st_d.rdata[15:0] = st_q.period;
						TW_IDX_PERIOD_BUF: st_d.rdata[15:0] = st_q.period_buf;
						default: begin
							for (int n = 0; n < 3; n++) begin
								if (idx == TW_IDX_COMPARE_REGISTER_0 + 6'(n * 2))
									st_d.rdata[15:0] = st_q.cmp[n];
								if (idx == TW_IDX_COMPARE_REGISTER_0_BUF + 6'(n * 2))
									st_d.rdata[15:0] = st_q.cmp_buf[n];
							end
						end
					endcase
				end
			end
			TW_BUS_ACK: begin
				st_d.bus = TW_BUS_IDLE;
				st_d.wait_rq = 1'b1;
			end
			default: begin
				st_d.bus = TW_BUS_IDLE;
				st_d.wait_rq = 1'b1;
			end
		endcase

		// Plain configuration registers
		if (we8) begin
			case (idx)
				TW_IDX_CTRL_A: st_d.enable = wd8[TW_POS_ENABLE];
				TW_IDX_CTRL_B: begin
					st_d.cmp_en = wd8[TW_POS_CMP_EN +: 3];
					st_d.auto_lock = wd8[TW_POS_AUTO_LOCK];
					st_d.mode = wd8[2:0];
					if (wd8[TW_POS_AUTO_LOCK])
						st_d.lock = 1'b1;
				end
				TW_IDX_OUT_VALUE: st_d.out_value = wd8[2:0];
				TW_IDX_SPLIT: st_d.split = wd8[TW_POS_SPLIT];
				default: ;
			endcase
		end

		// Counting sequence per waveform mode; reserved codes hold the count
		if (st_q.enable) begin
			case (st_q.mode)
				TW_WG_NORMAL, TW_WG_FREQUENCY: begin
					if (!st_q.dir) begin
						if (at_top) begin
							st_d.cnt = TW_RST_TIMER;
							hw_upd = 1'b1;
							st_d.ovf_p = 1'b1;
						end else
							st_d.cnt = st_q.cnt + 16'h0001;
					end else begin
						if (at_bot) begin
							st_d.cnt = top;
							st_d.ovf_p = 1'b1;
						end else
							st_d.cnt = st_q.cnt - 16'h0001;
					end
				end
				TW_WG_SINGLE: begin
					st_d.cnt = at_top ? TW_RST_TIMER : st_q.cnt + 16'h0001;
					hw_upd = at_bot;
					st_d.ovf_p = at_bot;
				end
				TW_WG_DUAL_HIGH, TW_WG_DUAL_BOTH, TW_WG_DUAL_LOW: begin
					if (!st_q.dir) begin
						if (at_top) begin
							st_d.dir = 1'b1;
							st_d.cnt = st_q.cnt - 16'h0001;
						end else
							st_d.cnt = st_q.cnt + 16'h0001;
					end else begin
						if (at_bot) begin
							st_d.dir = 1'b0;
							st_d.cnt = st_q.cnt + 16'h0001;
						end else
							st_d.cnt = st_q.cnt - 16'h0001;
					end
					hw_upd = at_bot;
					if (st_q.mode == TW_WG_DUAL_HIGH)
						st_d.ovf_p = at_top;
					else if (st_q.mode == TW_WG_DUAL_BOTH)
						st_d.ovf_p = at_top | at_bot;
					else
						st_d.ovf_p = at_bot;
				end
				default: ;
			endcase
		end

		// Software commands
		case (cmd)
			TW_CMD_UPDATE: force_upd = 1'b1;
			TW_CMD_RESTART: begin
				st_d.cnt = TW_RST_TIMER;
				st_d.dir = 1'b0;
			end
			TW_CMD_RESET: begin
				cmd_rst_req = 1'b1;
				hard_rst = !st_q.enable;
			end
			default: ;
		endcase

		// Set/clear pair for lock and direction
		if (we8 && idx == TW_IDX_CMD_DIR_CLR)
			{st_d.lock, st_d.dir} = 2'(apply_sc({2'b00, st_d.lock, st_d.dir},
				4'h0, wd8[3:0]));
		if (we8 && idx == TW_IDX_CMD_DIR_SET)
			{st_d.lock, st_d.dir} = 2'(apply_sc({2'b00, st_d.lock, st_d.dir},
				{2'b00, wd8[1:0]}, 4'h0));

		// Buffer transfer at UPDATE
		xfer = force_upd | (hw_upd & ~st_q.lock);
		st_d.update_p = hw_upd | force_upd;
		if (xfer) begin
			st_d.period = st_q.period_buf;
			st_d.cmp = st_q.cmp_buf;
			st_d.bv = 4'h0;
		end

		// Auto-lock: release when all enabled channels hold valid buffers
		all_valid = &(st_q.bv[TW_POS_CMP_BV +: 3] | ~st_q.cmp_en);
		if (st_q.auto_lock) begin
			if (xfer)
				st_d.lock = 1'b1;
			else if (all_valid)
				st_d.lock = 1'b0;
		end

		// Valid flags: software pair first, buffer writes win last
		if (we8 && idx == TW_IDX_BV_CLR)
			st_d.bv = apply_sc(st_d.bv, 4'h0, wd8[3:0]);
		if (we8 && idx == TW_IDX_BV_SET)
			st_d.bv = apply_sc(st_d.bv, wd8[3:0], 4'h0);
		if (wr_acc && idx == TW_IDX_PERIOD_BUF) begin
			st_d.period_buf = merge16(st_q.period_buf, avs_writedata,
				avs_byteenable);
			st_d.bv[TW_POS_PERIOD_BV] = 1'b1;
			any_buf_wr = 1'b1;
		end
		for (int n = 0; n < 3; n++) begin
			if (wr_acc && idx == TW_IDX_COMPARE_REGISTER_0_BUF + 6'(n * 2)) begin
				st_d.cmp_buf[n] = merge16(st_q.cmp_buf[n], avs_writedata,
					avs_byteenable);
				st_d.bv[TW_POS_CMP_BV + n] = 1'b1;
				any_buf_wr = 1'b1;
			end
		end

		// Hard reset of the counter state
		if (hard_rst) begin
			st_d.cnt = TW_RST_TIMER;
			st_d.period = TW_RST_TIMER;
			st_d.period_buf = TW_RST_TIMER;
			st_d.cmp = '0;
			st_d.cmp_buf = '0;
			st_d.dir = 1'b0;
			st_d.lock = 1'b0;
			st_d.bv = 4'h0;
		end

		// Waveform generator
		if (!st_q.enable)
			st_d.wave = st_q.out_value;
		else begin
			for (int n = 0; n < 3; n++) begin
				case (st_q.mode)
					TW_WG_FREQUENCY: begin
						if (st_q.cnt == st_q.cmp[n])
							st_d.wave[n] = ~st_q.wave[n];
					end
					TW_WG_SINGLE, TW_WG_DUAL_HIGH, TW_WG_DUAL_BOTH,
					TW_WG_DUAL_LOW: st_d.wave[n] = (st_q.cnt < st_q.cmp[n]);
					default: ;
				endcase
			end
		end
		for (int n = 0; n < 3; n++)
			st_d.pin_out[n] = st_q.cmp_en[n] ? st_q.wave[n]
				: port_value[n];
		st_d.pin_oe = st_q.cmp_en;
		st_d.logic_out = st_q.wave;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.bus <= TW_BUS_IDLE;
			st_q.wait_rq <= 1'b1;
			st_q.mode <= TW_RST_REG8[2:0];
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign avs_readdata = st_q.rdata;
	assign avs_waitrequest = st_q.wait_rq;
	assign waveform_output = st_q.pin_out;
	assign waveform_output_oe = st_q.pin_oe;
	assign logic_waveform = st_q.logic_out;
	assign update_pulse = st_q.update_p;
	assign overflow_pulse = st_q.ovf_p;
	assign split_select = st_q.split;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_CMD_READS_ZERO: assert property (
		!avs_waitrequest && avs_read
		&& (idx == TW_IDX_CMD_DIR_SET || idx == TW_IDX_CMD_DIR_CLR)
		|-> avs_readdata[3:2] == 2'b00)
		else $error("command field read back non-zero");
	AST_NORMAL_TOP: assert property (
		clk_en && st_q.enable && st_q.mode == TW_WG_NORMAL && !st_q.dir
		&& st_q.cnt == st_q.period && cmd == TW_CMD_NONE
		|=> update_pulse && overflow_pulse && st_q.cnt == 16'h0000)
		else $error("normal mode missed events at top");
	AST_SINGLE_BOTTOM: assert property (
		clk_en && st_q.enable && st_q.mode == TW_WG_SINGLE
		&& st_q.cnt == 16'h0000 |=> update_pulse && overflow_pulse)
		else $error("single ramp missed events at bottom");
	AST_DUAL_HIGH_OVF: assert property (
		clk_en && st_q.enable && st_q.mode == TW_WG_DUAL_HIGH
		&& st_q.cnt != 16'h0000 |=> overflow_pulse == $past(at_top))
		else $error("dual ramp overflow not at top");
	AST_LOCK_HOLDS: assert property (
		clk_en && hw_upd && st_q.lock && !force_upd && !hard_rst
		|=> st_q.period == $past(st_q.period) && st_q.cmp == $past(st_q.cmp))
		else $error("locked update copied buffers");
	AST_FORCE_COPIES: assert property (
		clk_en && force_upd
		|=> st_q.period == $past(st_q.period_buf) && update_pulse)
		else $error("forced update did not copy buffers");
	AST_BV_CLEARED: assert property (
		clk_en && xfer && !any_buf_wr && !(we8 && idx == TW_IDX_BV_SET)
		|=> st_q.bv == 4'h0)
		else $error("buffer valid flags survived update");
	AST_RESET_IGNORED: assert property (
		clk_en && cmd_rst_req && st_q.enable && !xfer
		|=> st_q.period == $past(st_q.period))
		else $error("hard reset acted while enabled");
	AST_DISABLED_LEVEL: assert property (
		clk_en && !st_q.enable |=> st_q.wave == $past(st_q.out_value))
		else $error("disabled output level not taken from value bits");
	AST_PIN_ROUTE: assert property (
		clk_en |=> waveform_output[0] == ($past(st_q.cmp_en[0])
		? $past(st_q.wave[0]) : $past(port_value[0])))
		else $error("pin routing ignores compare enable");
	AST_SET_LOCK: assert property (
		clk_en && we8 && idx == TW_IDX_CMD_DIR_SET && wd8[1]
		&& !st_q.auto_lock && !hard_rst |=> st_q.lock)
		else $error("set register did not set lock");
	AST_CLR_DIR: assert property (
		clk_en && we8 && idx == TW_IDX_CMD_DIR_CLR && wd8[0] && !st_q.enable
		|=> !st_q.dir)
		else $error("clear register did not clear direction");
	AST_BUS_ONE_WAIT: assert property (
		clk_en && (avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle after request");

	COV_FORCED_UPDATE: cover property (clk_en && force_upd && st_q.lock);
	COV_AUTO_RELEASE: cover property (st_q.auto_lock && $fell(st_q.lock));
	COV_DUAL_TURN: cover property (st_q.enable && $rose(st_q.dir));

endmodule : tw_timer_ctrl

// ---- sim/tw_pad_model.sv ----
// Pad and configurable-logic side of the three waveform outputs.
// Assumes the port peripheral owns every pad that the timer does not drive.
`timescale 1ns/100ps
module tw_pad_model
	import tw_pkg::*;
(
	input  wire logic [2:0] pad_drive,
	input  wire logic [2:0] pad_oe,
	input  wire logic [2:0] port_level,
	input  wire logic [2:0] logic_in,
	output logic [2:0]      pin_level,
	output logic [2:0]      logic_seen
);
	// Timer level reaches the pad only while it drives
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_level[i] = pad_oe[i] ? pad_drive[i] : port_level[i];
		end
	end
	assign logic_seen = logic_in;
endmodule : tw_pad_model

// ---- sim/tw_timer_ctrl_test.sv ----
// Self-checking bench for the timer waveform control block.
// Assumes the design answers each bus request after one wait cycle.
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
	$display("FAIL %0t got %h exp %h", $time, (a), (e)); end end
module tw_timer_ctrl_test;
	import tw_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        clk_en = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [2:0]  port_value = 3'h2;
	logic [2:0]  wo, wo_oe, lw, pin, seen;
	logic        upd, ovf, split;
	logic        meas = 1'b0;
	int          bad_count = 0;
	int          n_compared = 0;
	int          n_ovf, n_both, cycles = 0;
	logic [31:0] rd;
	logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};

	always #50 clk = ~clk;

	tw_timer_ctrl uut (
		.clk                (clk),
		.reset_n            (reset_n),
		.clk_en             (clk_en),
		.avs_address        (avs_address),
		.avs_read           (avs_read),
		.avs_write          (avs_write),
		.avs_writedata      (avs_writedata),
		.avs_byteenable     (4'hf),
		.avs_readdata       (avs_readdata),
		.avs_waitrequest    (avs_waitrequest),
		.port_value         (port_value),
		.waveform_output    (wo),
		.waveform_output_oe (wo_oe),
		.logic_waveform     (lw),
		.update_pulse       (upd),
		.overflow_pulse     (ovf),
		.split_select       (split)
	);

	tw_pad_model pads (
		.pad_drive  (wo),
		.pad_oe     (wo_oe),
		.port_level (port_value),
		.logic_in   (lw),
		.pin_level  (pin),
		.logic_seen (seen)
	);

	task automatic close_out;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	// One Avalon transfer; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] idx,
		input logic [31:0] wd);
		@(posedge clk);
		avs_address   <= {idx, 2'b00};
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= wd;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
		bus(1'b1, idx, wd);
	endtask : wr

	task automatic rc(input logic [5:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		`CHK(rd, exp)
	endtask : rc

	// Pulses seen together with an update versus alone
	always @(posedge clk) begin
		cycles++;
		if (meas && ovf === 1'b1) begin
			n_ovf++;
			if (upd === 1'b1) n_both++;
		end
		if (cycles > 20000) begin
			bad_count++;
			close_out();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 2; i < 8; i++) rc(i[5:0], 32'h0);
		rc(6'h3f, 32'h0);
		wr(6'h3f, 32'hff);
		rc(6'h3f, 32'h0);
		$display("reset values done");

		wr(TW_IDX_CMD_DIR_SET, 32'h03);
		rc(TW_IDX_CMD_DIR_CLR, 32'h03);
		rc(TW_IDX_CMD_DIR_SET, 32'h03);
		wr(TW_IDX_CMD_DIR_CLR, 32'h01);
		rc(TW_IDX_CMD_DIR_SET, 32'h02);
		wr(TW_IDX_CMD_DIR_SET, 32'h09);
		rc(TW_IDX_CMD_DIR_SET, 32'h03);
		wr(TW_IDX_CMD_DIR_SET, 32'h08);
		rc(TW_IDX_CMD_DIR_CLR, 32'h02);
		$display("set clear pair done");

		wr(TW_IDX_PERIOD_BUF, 32'h0004);
		rc(TW_IDX_BV_SET, 32'h01);
		wr(TW_IDX_COMPARE_REGISTER_0_BUF, 32'h0004);
		rc(TW_IDX_BV_CLR, 32'h03);
		wr(TW_IDX_BV_CLR, 32'h02);
		rc(TW_IDX_BV_SET, 32'h01);
		wr(TW_IDX_BV_SET, 32'h0c);
		rc(TW_IDX_BV_CLR, 32'h0d);
		wr(TW_IDX_CMD_DIR_SET, 32'h04);
		rc(TW_IDX_BV_SET, 32'h00);
		rc(TW_IDX_PERIOD, 32'h0004);
		rc(TW_IDX_COMPARE_REGISTER_0, 32'h0004);
		$display("forced update done");

		wr(TW_IDX_PERIOD_BUF, 32'h0006);
		wr(TW_IDX_CTRL_A, 32'h01);
		repeat (30) @(posedge clk);
		wr(TW_IDX_CTRL_A, 32'h00);
		rc(TW_IDX_PERIOD, 32'h0004);
		wr(TW_IDX_CMD_DIR_CLR, 32'h02);
		wr(TW_IDX_CTRL_A, 32'h01);
		repeat (30) @(posedge clk);
		wr(TW_IDX_CTRL_A, 32'h00);
		rc(TW_IDX_PERIOD, 32'h0006);
		$display("lock done");

		foreach (modes[k]) begin
			wr(TW_IDX_CMD_DIR_SET, 32'h08);
			wr(TW_IDX_CTRL_B, {29'h0, modes[k]});
			wr(TW_IDX_CTRL_A, 32'h01);
			n_ovf = 0;
			n_both = 0;
			meas <= 1'b1;
			repeat (80) @(posedge clk);
			meas <= 1'b0;
			wr(TW_IDX_CTRL_A, 32'h00);
			case (modes[k])
			3'h5: `CHK(n_both == 0 && n_ovf > 0, 1'b1)
			3'h6: `CHK(n_both > 0 && n_ovf > n_both, 1'b1)
			default: `CHK(n_both == n_ovf, n_ovf > 0)
			endcase
		end
		$display("waveform modes done");

		wr(TW_IDX_CTRL_B, 32'h00);
		wr(TW_IDX_OUT_VALUE, 32'h05);
		repeat (3) @(posedge clk);
		`CHK(seen, 3'h5)
		`CHK(pin, 3'h2)
		`CHK(wo_oe, 3'h0)
		clk_en     <= 1'b0;
		port_value <= 3'h6;
		repeat (3) @(posedge clk);
		`CHK(wo, 3'h2)
		clk_en <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(wo, 3'h6)
		wr(TW_IDX_CTRL_B, 32'h70);
		repeat (3) @(posedge clk);
		`CHK(pin, 3'h5)
		`CHK(wo_oe, 3'h7)
		$display("output values done");

		wr(TW_IDX_SPLIT, 32'h01);
		rc(TW_IDX_SPLIT, 32'h01);
		`CHK(split, 1'b1)
		$display("split done");

		wr(TW_IDX_CTRL_A, 32'h01);
		wr(TW_IDX_CMD_DIR_SET, 32'h0c);
		rc(TW_IDX_PERIOD, 32'h0006);
		wr(TW_IDX_CTRL_A, 32'h00);
		wr(TW_IDX_CMD_DIR_SET, 32'h0c);
		rc(TW_IDX_PERIOD, 32'h0000);
		rc(TW_IDX_CMD_DIR_SET, 32'h00);
		$display("hard reset done");

		wr(TW_IDX_CTRL_B, 32'h18);
		rc(TW_IDX_CMD_DIR_SET, 32'h02);
		wr(TW_IDX_COMPARE_REGISTER_0_BUF, 32'h0003);
		rc(TW_IDX_CMD_DIR_SET, 32'h00);
		wr(TW_IDX_CMD_DIR_SET, 32'h04);
		rc(TW_IDX_CMD_DIR_SET, 32'h02);
		rc(TW_IDX_COMPARE_REGISTER_0, 32'h0003);
		$display("auto lock done");
		close_out();
	end
endmodule : tw_timer_ctrl_test
